// File: src/phy_regs_pkg.sv
// constants shared by the management register block and its serial slave
package phy_regs_pkg;

	// ==========================================================
	// register offsets
	localparam logic [4:0] REG_INT_CTRL_STATUS = 5'h1b;
	localparam logic [4:0] REG_CABLE_DIAG = 5'h1d;
	localparam logic [4:0] REG_PHY_CTRL_FIRST = 5'h1e;

	// ==========================================================
	// interrupt control/status fields
	localparam int INT_EN_LSB = 8;
	localparam int INT_EN_MSB = 10;
	localparam int INT_FLAG_COUNT = 8;
	localparam int INT_FLAG_JABBER = 7;
	localparam int INT_FLAG_RX_ERROR = 6;
	localparam int INT_FLAG_PAGE_RX = 5;
	localparam int INT_FLAG_PAR_DET_FAULT = 4;
	localparam int INT_FLAG_LP_ACK = 3;
	localparam int INT_FLAG_LINK_DOWN = 2;
	localparam int INT_FLAG_REMOTE_FAULT = 1;
	localparam int INT_FLAG_LINK_UP = 0;
	localparam logic [2:0] INT_EN_RESET = 3'h0;
	localparam logic [7:0] INT_FLAG_RESET = 8'h00;
	localparam logic IRQ_ACTIVE_LEVEL_RESET = 1'b0;

	// ==========================================================
	// cable diagnostic fields
	localparam int DIAG_START_BIT = 15;
	localparam int DIAG_RESULT_MSB = 14;
	localparam int DIAG_RESULT_LSB = 13;
	localparam int DIAG_SHORT_BIT = 12;
	localparam int DIAG_RSVD_MSB = 11;
	localparam int DIAG_RSVD_LSB = 9;
	localparam int DIAG_DIST_MSB = 8;
	localparam logic [1:0] DIAG_RESULT_RESET = 2'h0;
	localparam logic [2:0] DIAG_RSVD_RESET = 3'h0;
	localparam logic [8:0] DIAG_DIST_RESET = 9'h000;
	localparam logic DIAG_START_RESET = 1'b0;
	localparam logic DIAG_SHORT_RESET = 1'b0;
	localparam logic [1:0] DIAG_RESULT_NORMAL = 2'h0;
	localparam logic [1:0] DIAG_RESULT_OPEN = 2'h1;
	localparam logic [1:0] DIAG_RESULT_SHORT = 2'h2;
	localparam logic [1:0] DIAG_RESULT_FAILED = 2'h3;

	// ==========================================================
	// phy control first fields
	localparam int PAUSE_CAP_BIT = 9;
	localparam logic PAUSE_CAP_RESET = 1'b0;

	// ==========================================================
	// management frame
	localparam logic [5:0] MGMT_PREAMBLE_LEN = 6'h20;
	localparam logic [1:0] MGMT_OP_READ = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
	localparam logic [3:0] MGMT_HDR_LAST = 4'hb;
	localparam logic [3:0] MGMT_DATA_LAST = 4'hf;

endpackage : phy_regs_pkg

// File: src/mdio_slave.sv
// serial management frame slave giving a register access port
`timescale 1ns/10ps
`default_nettype none
module mdio_slave
	import phy_regs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe,
	input wire logic [4:0] phyAddr,
	output logic [4:0] regAddr,
	output logic [15:0] wrData,
	output logic wrStrobe,
	output logic rdStrobe,
	input wire logic [15:0] rdData
);
	typedef enum {ST_PRE, ST_START, ST_HDR, ST_TA, ST_DATA} mgmt_state_e;

	mgmt_state_e state_q;
	logic mdcPrev_q;
	logic [5:0] ones_q;
	logic [3:0] cnt_q;
	logic [11:0] hdr_q;
	logic [15:0] sh_q;
	logic isRead_q;
	logic mdcRise;
	logic [11:0] hdrNext;

	assign mdcRise = mdc & ~mdcPrev_q;
	assign hdrNext = {hdr_q[10:0], mdioIn};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mdcPrev_q <= 1'b0;
		end else begin
			mdcPrev_q <= mdc;
		end
	end

	// ==========================================================
	// frame sequencer, one step per mdc rising edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_PRE;
			ones_q <= 6'h00;
			cnt_q <= 4'h0;
			hdr_q <= 12'h000;
			sh_q <= 16'h0000;
			isRead_q <= 1'b0;
			regAddr <= 5'h00;
			wrData <= 16'h0000;
			wrStrobe <= 1'b0;
			rdStrobe <= 1'b0;
			mdioOut <= 1'b0;
			mdioOe <= 1'b0;
		end else begin
			wrStrobe <= 1'b0;
			rdStrobe <= 1'b0;
			if (mdcRise) begin
				unique case (state_q)
					ST_PRE: begin
						if (mdioIn) begin
							if (ones_q != MGMT_PREAMBLE_LEN) begin
								ones_q <= ones_q + 6'h01;
							end
						end else begin
							ones_q <= 6'h00;
							if (ones_q == MGMT_PREAMBLE_LEN) begin
								state_q <= ST_START;
							end
						end
					end
					ST_START: begin
						cnt_q <= 4'h0;
						state_q <= mdioIn ? ST_HDR : ST_PRE;
					end
					ST_HDR: begin
						hdr_q <= hdrNext;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == MGMT_HDR_LAST) begin
							cnt_q <= 4'h0;
							regAddr <= hdrNext[4:0];
							isRead_q <= (hdrNext[11:10] == MGMT_OP_READ);
							if (hdrNext[9:5] != phyAddr) begin
								state_q <= ST_PRE;
							end else if (hdrNext[11:10] == MGMT_OP_READ) begin
								rdStrobe <= 1'b1;
								state_q <= ST_TA;
							end else if (hdrNext[11:10] == MGMT_OP_WRITE) begin
								state_q <= ST_TA;
							end else begin
								state_q <= ST_PRE;
							end
						end
					end
					ST_TA: begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h0) begin
							// second turnaround bit driven low on reads
							mdioOe <= isRead_q;
							mdioOut <= 1'b0;
						end else begin
							cnt_q <= 4'h0;
							state_q <= ST_DATA;
							if (isRead_q) begin
								mdioOut <= rdData[15];
								sh_q <= {rdData[14:0], 1'b0};
							end
						end
					end
					ST_DATA: begin
						cnt_q <= cnt_q + 4'h1;
						if (isRead_q) begin
							mdioOut <= sh_q[15];
							sh_q <= {sh_q[14:0], 1'b0};
						end else begin
							sh_q <= {sh_q[14:0], mdioIn};
						end
						if (cnt_q == MGMT_DATA_LAST) begin
							mdioOe <= 1'b0;
							mdioOut <= 1'b0;
							state_q <= ST_PRE;
							if (!isRead_q) begin
								wrData <= {sh_q[14:0], mdioIn};
								wrStrobe <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end
endmodule : mdio_slave
`default_nettype wire

// File: src/phy_irq_and_cable_diag_regs.sv
// interrupt, cable diagnostic and first control registers of the transceiver
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - link-down interrupt enable, bit 10, RW
// - remote fault interrupt enable, bit 9
// - link-up interrupt enable, bit 8
// - receive error flag bit 6, clears on read
// - page received bit 5, parallel fault bit 4
// - link partner acknowledge flag bit 3
// - link-down bit 2, remote fault bit 1
// - link-up flag bit 0, clears on read
// - writing start bit runs test, self-clears
// - result code in bits 14:13
// - short cable flag in bit 12
// - pause capability read-only at bit 9
// - interrupt polarity set by level control
// - self-cleared bits cleared by device action
module phy_irq_and_cable_diag_regs
	import phy_regs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe,
	input wire logic [4:0] phyAddr,
	input wire logic evJabber,
	input wire logic evRxError,
	input wire logic evPageRx,
	input wire logic evParDetFault,
	input wire logic evLpAck,
	input wire logic evLinkDown,
	input wire logic evRemoteFault,
	input wire logic evLinkUp,
	input wire logic intActiveHigh,
	input wire logic pauseCapable,
	output logic cableTestRun,
	input wire logic cableTestDone,
	input wire logic [1:0] cableResult,
	input wire logic cableShort,
	input wire logic [8:0] cableDistance,
	output logic irqOut
);
	logic [4:0] regAddr;
	logic [15:0] wrData;
	logic wrStrobe;
	logic rdStrobe;
	logic [15:0] rdData_q;
	logic [15:0] rdData_d;
	logic [2:0] intEn_q;
	logic [7:0] flags_q;
	logic [7:0] evVec;
	logic flagClear;
	logic intWrite;
	logic diagWrite;
	logic [1:0] diagResult_q;
	logic diagShort_q;
	logic [2:0] diagRsvd_q;
	logic [8:0] diagDist_q;
	logic pauseCap_q;
	logic irqAny;

	// ==========================================================
	// management access
	mdio_slave i_mdio_slave (
		.clk_sys(clk_sys),
		.rst(rst),
		.mdc(mdc),
		.mdioIn(mdioIn),
		.mdioOut(mdioOut),
		.mdioOe(mdioOe),
		.phyAddr(phyAddr),
		.regAddr(regAddr),
		.wrData(wrData),
		.wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe),
		.rdData(rdData_q)
	);

	// ==========================================================
	// register write decode
	assign intWrite = wrStrobe && (regAddr == REG_INT_CTRL_STATUS);
	assign diagWrite = wrStrobe && (regAddr == REG_CABLE_DIAG);

	// ==========================================================
	// interrupt enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			intEn_q <= INT_EN_RESET;
		end else if (intWrite) begin
			intEn_q <= wrData[INT_EN_MSB:INT_EN_LSB];
		end
	end

	// ==========================================================
	// event flags, set wins over read clear
	assign evVec[INT_FLAG_JABBER] = evJabber;
	assign evVec[INT_FLAG_RX_ERROR] = evRxError;
	assign evVec[INT_FLAG_PAGE_RX] = evPageRx;
	assign evVec[INT_FLAG_PAR_DET_FAULT] = evParDetFault;
	assign evVec[INT_FLAG_LP_ACK] = evLpAck;
	assign evVec[INT_FLAG_LINK_DOWN] = evLinkDown;
	assign evVec[INT_FLAG_REMOTE_FAULT] = evRemoteFault;
	assign evVec[INT_FLAG_LINK_UP] = evLinkUp;
	assign flagClear = rdStrobe && (regAddr == REG_INT_CTRL_STATUS);

	genvar gi;
	generate
		for (gi = 0; gi < INT_FLAG_COUNT; gi++) begin : g_flag
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					flags_q[gi] <= INT_FLAG_RESET[gi];
				end else if (evVec[gi]) begin
					flags_q[gi] <= 1'b1;
				end else if (flagClear) begin
					flags_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// cable diagnostic reserved bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			diagRsvd_q <= DIAG_RSVD_RESET;
		end else if (diagWrite) begin
			diagRsvd_q <= wrData[DIAG_RSVD_MSB:DIAG_RSVD_LSB];
		end
	end

	// ==========================================================
	// cable test start bit, self-clears on done
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cableTestRun <= DIAG_START_RESET;
		end else if (cableTestRun) begin
			// a second start while running is ignored
			if (cableTestDone) begin
				cableTestRun <= 1'b0;
			end
		end else if (diagWrite && wrData[DIAG_START_BIT]) begin
			cableTestRun <= 1'b1;
		end
	end

	// ==========================================================
	// results, frozen while running, captured together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			diagResult_q <= DIAG_RESULT_RESET;
			diagShort_q <= DIAG_SHORT_RESET;
			diagDist_q <= DIAG_DIST_RESET;
		end else if (cableTestRun && cableTestDone) begin
			diagResult_q <= cableResult;
			diagShort_q <= cableShort;
			diagDist_q <= cableDistance;
		end
	end

	// ==========================================================
	// flow control capability
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pauseCap_q <= PAUSE_CAP_RESET;
		end else begin
			pauseCap_q <= pauseCapable;
		end
	end

	// ==========================================================
	// read data, latched before flags clear
	always_comb begin
		rdData_d = 16'h0000;
		unique case (regAddr)
			REG_INT_CTRL_STATUS: begin
				rdData_d[INT_EN_MSB:INT_EN_LSB] = intEn_q;
				rdData_d[INT_FLAG_JABBER:INT_FLAG_LINK_UP] = flags_q;
			end
			REG_CABLE_DIAG: begin
				rdData_d[DIAG_START_BIT] = cableTestRun;
				rdData_d[DIAG_RESULT_MSB:DIAG_RESULT_LSB] = diagResult_q;
				rdData_d[DIAG_SHORT_BIT] = diagShort_q;
				rdData_d[DIAG_RSVD_MSB:DIAG_RSVD_LSB] = diagRsvd_q;
				rdData_d[DIAG_DIST_MSB:0] = diagDist_q;
			end
			REG_PHY_CTRL_FIRST: begin
				rdData_d[PAUSE_CAP_BIT] = pauseCap_q;
			end
			default: begin
				rdData_d = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdData_q <= 16'h0000;
		end else if (rdStrobe) begin
			rdData_q <= rdData_d;
		end
	end

	// ==========================================================
	// interrupt output
	// flags 7:3 have no enable here, never reach the pin
	assign irqAny = |(flags_q[INT_FLAG_LINK_DOWN:INT_FLAG_LINK_UP] & intEn_q);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irqOut <= ~IRQ_ACTIVE_LEVEL_RESET;
		end else begin
			irqOut <= intActiveHigh ? irqAny : ~irqAny;
		end
	end
endmodule : phy_irq_and_cable_diag_regs
`default_nettype wire

// File: tb/phy_regs_props.sv
// port checker for the interrupt and cable diagnostic registers
`timescale 1ns/10ps
`default_nettype none
module phy_regs_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe,
	input wire logic evLinkDown,
	input wire logic evRemoteFault,
	input wire logic evLinkUp,
	input wire logic intActiveHigh,
	input wire logic cableTestRun,
	input wire logic cableTestDone,
	input wire logic irqOut
);
	// ====
	// recent mdc rises and interrupt causes
	logic mdc_q, pol_q, seen_q, rise, cause;
	logic [5:0] rise_q, cause_q;
	assign rise = mdc & ~mdc_q;
	assign cause = rise | evLinkDown | evRemoteFault | evLinkUp | (intActiveHigh ^ pol_q);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mdc_q <= 1'b0;
			pol_q <= 1'b0;
			seen_q <= 1'b0;
			rise_q <= 6'h00;
			cause_q <= 6'h00;
		end else begin
			mdc_q <= mdc;
			pol_q <= intActiveHigh;
			seen_q <= seen_q | evLinkDown | evRemoteFault | evLinkUp;
			rise_q <= {rise_q[4:0], rise};
			cause_q <= {cause_q[4:0], cause};
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	done_clears_run_a: assert property (cableTestRun && cableTestDone |=> !cableTestRun)
		else $error("run kept after done");
	run_holds_a: assert property (cableTestRun && !cableTestDone |=> cableTestRun)
		else $error("run dropped early");
	run_by_write_a: assert property ($rose(cableTestRun) |-> |rise_q)
		else $error("run rose outside frame");
	irq_idle_level_a: assert property (!seen_q && !$past(rst) |-> irqOut == !$past(intActiveHigh))
		else $error("irq idle level wrong");
	irq_has_cause_a: assert property (irqOut != $past(irqOut) && !$past(rst) |-> |cause_q)
		else $error("irq moved without cause");
	ta_low_a: assert property ($rose(mdioOe) |-> !mdioOut)
		else $error("turnaround not low");
	oe_holds_a: assert property ($rose(mdioOe) |=> mdioOe[*8])
		else $error("drive released early");
	out_after_rise_a: assert property ($changed(mdioOut) |-> |rise_q[3:0])
		else $error("data moved off mdc rise");
	done_c: cover property (cableTestRun && cableTestDone);
	irq_on_c: cover property (irqOut == intActiveHigh);
	answer_c: cover property ($rose(mdioOe));
endmodule : phy_regs_props
bind phy_irq_and_cable_diag_regs phy_regs_props i_phy_regs_props (.clk_sys, .rst, .mdc, .mdioOut, .mdioOe,
	.evLinkDown, .evRemoteFault, .evLinkUp, .intActiveHigh, .cableTestRun, .cableTestDone, .irqOut);
`default_nettype wire

// File: tb/mgmt_host_model.sv
// management host sending register frames on mdc and mdio
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model (
	input wire logic clk_sys,
	output logic mdc,
	output logic hostOe,
	output logic hostOut,
	input wire logic mdioWire
);
	// ====
	// one bit per mdc period, line sampled just before the rise
	initial begin
		mdc = 1'b0;
		hostOe = 1'b0;
		hostOut = 1'b1;
	end
	task automatic mbit(input logic b, output logic s);
		hostOut = b;
		repeat (4) @(negedge clk_sys);
		s = mdioWire;
		mdc = 1'b1;
		repeat (4) @(negedge clk_sys);
		mdc = 1'b0;
	endtask : mbit
	task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] q);
		logic [47:0] h;
		logic s;
		h = {32'hffffffff, 2'b01, rd, !rd, pa, ra, 2'b10};
		hostOe = 1'b1;
		for (int i = 47; i >= 0; i--) begin
			if (i == 1) hostOe = !rd;
			mbit(h[i], s);
		end
		for (int i = 15; i >= 0; i--) mbit(wd[i], q[i]);
		hostOe = 1'b0;
		// let an edge pass before the next frame drives again
		@(negedge clk_sys);
	endtask : frame
endmodule : mgmt_host_model
`default_nettype wire

// File: tb/phy_irq_and_cable_diag_regs_test.sv
// bench for the interrupt, cable diagnostic and control registers
`timescale 1ns/10ps
`default_nettype none
module phy_irq_and_cable_diag_regs_test;
	// ====
	// stimulus and checks
	logic clk_sys = 1'b0, rst = 1'b1, intActiveHigh = 1'b0, pauseCapable = 1'b0, cableTestDone = 1'b0;
	logic cableShort = 1'b0, mdc, hostOe, hostOut, mdioOut, mdioOe, mdioWire, cableTestRun, irqOut;
	logic [1:0] cableResult = 2'h0;
	logic [7:0] ev = 8'h00;
	logic [8:0] cableDistance = 9'h000;
	logic [15:0] q, st = 16'h0000;
	logic [15:0] rows [9] = '{16'h0101, 16'h0202, 16'h0404, 16'h0808, 16'h1010, 16'h2020, 16'h4040, 16'h8080,
		16'hffff};
	int bad_count = 0;
	int num_checks = 0;
	always #25 clk_sys = ~clk_sys;
	assign mdioWire = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);
	mgmt_host_model i_mgmt_host_model (.clk_sys, .mdc, .hostOe, .hostOut, .mdioWire);
	phy_irq_and_cable_diag_regs i_phy_irq_and_cable_diag_regs (.clk_sys, .rst, .mdc, .mdioIn(mdioWire), .mdioOut,
		.mdioOe, .phyAddr(5'h03), .evJabber(ev[7]), .evRxError(ev[6]), .evPageRx(ev[5]), .evParDetFault(ev[4]),
		.evLpAck(ev[3]), .evLinkDown(ev[2]), .evRemoteFault(ev[1]), .evLinkUp(ev[0]), .intActiveHigh,
		.pauseCapable, .cableTestRun, .cableTestDone, .cableResult, .cableShort, .cableDistance, .irqOut);
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
		i_mgmt_host_model.frame(1'b1, 5'h03, ra, 16'h0000, q);
		chk($sformatf("reg %h", ra), q, exp);
	endtask : rdc
	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		i_mgmt_host_model.frame(1'b0, 5'h03, ra, wd, q);
	endtask : wr
	task automatic pulse(input logic [7:0] e);
		ev = e;
		@(negedge clk_sys);
		ev = 8'h00;
		repeat (4) @(negedge clk_sys);
	endtask : pulse
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		foreach (rows[i]) begin
			pulse(rows[i][15:8]);
			rdc(5'h1b, {8'h00, rows[i][7:0]});
			rdc(5'h1b, 16'h0000);
		end
		$display("flag rows done");
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		rdc(5'h1b, 16'h0000);
		rdc(5'h1d, 16'h0000);
		rdc(5'h1e, 16'h0000);
		chk("irq", {15'h0, irqOut}, 16'h0001);
		$display("reset done");
		intActiveHigh = 1'b1;
		for (int k = 0; k < 3; k++) begin
			wr(5'h1b, 16'h0100 << k);
			pulse(8'h01 << ((k + 1) % 3));
			chk("irq", {15'h0, irqOut}, 16'h0000);
			pulse(8'h01 << k);
			chk("irq", {15'h0, irqOut}, 16'h0001);
			rdc(5'h1b, (16'h0101 << k) | (16'h0001 << ((k + 1) % 3)));
			chk("irq", {15'h0, irqOut}, 16'h0000);
		end
		intActiveHigh = 1'b0;
		pulse(8'h04);
		chk("irq", {15'h0, irqOut}, 16'h0000);
		rdc(5'h1b, 16'h0404);
		$display("interrupt done");
		for (int c = 0; c < 4; c++) begin
			cableResult = 2'(c);
			cableShort = c[0];
			cableDistance = 9'h1ff >> c;
			wr(5'h1d, 16'h8000 | (16'(c) << 9));
			chk("run", {15'h0, cableTestRun}, 16'h0001);
			rdc(5'h1d, st | 16'h8000 | (16'(c) << 9));
			cableTestDone = 1'b1;
			@(negedge clk_sys);
			cableTestDone = 1'b0;
			st = {1'b0, 2'(c), c[0], 3'h0, 9'h1ff >> c};
			rdc(5'h1d, st | (16'(c) << 9));
		end
		cableDistance = 9'h000;
		pulse(8'h00);
		cableTestDone = 1'b1;
		@(negedge clk_sys);
		cableTestDone = 1'b0;
		rdc(5'h1d, st | 16'h0600);
		$display("cable done");
		pauseCapable = 1'b1;
		wr(5'h1e, 16'hffff);
		rdc(5'h1e, 16'h0200);
		rdc(5'h1c, 16'h0000);
		i_mgmt_host_model.frame(1'b0, 5'h04, 5'h1b, 16'h0000, q);
		rdc(5'h1b, 16'h0400);
		$display("control done");
		final_report();
	end
	initial begin
		#3000000;
		bad_count++;
		final_report();
	end
endmodule : phy_irq_and_cable_diag_regs_test
`default_nettype wire
